// [rpsr_pkg.sv]
// shared constants for the receive port status register group
package rpsr_pkg;

	// receive ports served by this group
	localparam int NUM_PORTS = 4;
	localparam int PORT_W = 2;

	// register bus widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [7:0] ADDR_PORT_SELECT = 8'h4C;
	localparam logic [7:0] ADDR_LINK_STATUS_TWO = 8'h4E;
	localparam logic [7:0] ADDR_FREQ_INTEGER_MHZ = 8'h4F;
	localparam logic [7:0] ADDR_FREQ_FRACTION = 8'h50;
	localparam logic [7:0] ADDR_REMOTE_ALARM = 8'h51;
	localparam logic [7:0] ADDR_REMOTE_VOLTAGE = 8'h52;
	localparam logic [7:0] ADDR_REMOTE_TEMP = 8'h53;

	// port select register layout
	localparam int PSEL_PORT_LSB = 0;

	// status register two bit positions
	localparam int STS_LINE_LEN_UNSTEADY = 7;
	localparam int STS_LINE_LEN_CHANGED = 6;
	localparam int STS_ENCODING_ERROR = 5;
	localparam int STS_BUFFER_ERROR = 4;
	localparam int STS_CSI_ERROR = 3;
	localparam int STS_FREQ_SETTLED = 2;
	localparam int STS_CLOCK_ABSENT = 1;
	localparam int STS_LINE_CNT_CHANGED = 0;

	// sensor field widths and positions
	localparam int ALARM_W = 6;
	localparam int LEVEL_W = 3;
	localparam int VOLT1_LSB = 4;
	localparam int VOLT0_LSB = 0;
	localparam int TEMP_LSB = 0;

	// frequency measurement: integer MHz byte and 1/256 MHz byte
	localparam int FREQ_W = 16;

	// video timing counters
	localparam int LINE_W = 16;

	// link error threshold field; encoding errors seen only above this
	localparam int THRESH_W = 3;
	localparam logic [2:0] ENC_ERR_MIN_THRESH = 3'h1;

	// reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] RESET_PORT = 2'h0;
	localparam logic [15:0] RESET_FREQ = 16'h0000;
	localparam logic [15:0] RESET_LINE = 16'h0000;

endpackage

// [rpsr_line_tracker.sv]
// video line length and line count change detector for one receive port
`timescale 1ns/1ps
module rpsr_line_tracker (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic line_end,
	input wire logic [rpsr_pkg::LINE_W-1:0] line_length,
	input wire logic frame_end,
	output logic unsteady_evt_q,
	output logic len_changed_evt_q,
	output logic cnt_changed_evt_q
);
	import rpsr_pkg::*;

	logic have_first_q, have_first_d;
	logic mismatch_q, mismatch_d;
	logic have_prev_q, have_prev_d;
	logic [LINE_W-1:0] first_len_q, first_len_d;
	logic [LINE_W-1:0] prev_len_q, prev_len_d;
	logic [LINE_W-1:0] cnt_q, cnt_d;
	logic [LINE_W-1:0] prev_cnt_q, prev_cnt_d;
	logic unsteady_d, len_chg_d, cnt_chg_d;

	// per-frame bookkeeping; a line ending with the frame still counts in it
	always_comb
	begin
		logic [LINE_W-1:0] cnt_now;
		logic [LINE_W-1:0] first_now;
		logic mis_now;
		logic first_seen;
		cnt_now = line_end ? LINE_W'(cnt_q + 1'b1) : cnt_q;
		first_now = (line_end && !have_first_q) ? line_length : first_len_q;
		first_seen = have_first_q | line_end;
		mis_now = mismatch_q | (line_end && have_first_q && line_length != first_len_q);
		len_chg_d = line_end && !have_first_q && have_prev_q && line_length != prev_len_q;
		unsteady_d = frame_end && mis_now;
		cnt_chg_d = frame_end && have_prev_q && cnt_now != prev_cnt_q;
		have_first_d = first_seen;
		first_len_d = first_now;
		mismatch_d = mis_now;
		cnt_d = cnt_now;
		prev_len_d = prev_len_q;
		prev_cnt_d = prev_cnt_q;
		have_prev_d = have_prev_q;
		if (frame_end)
		begin
			// a frame with no lines leaves the reference untouched
			have_prev_d = have_prev_q | first_seen;
			prev_len_d = first_seen ? first_now : prev_len_q;
			prev_cnt_d = first_seen ? cnt_now : prev_cnt_q;
			have_first_d = 1'b0;
			mismatch_d = 1'b0;
			cnt_d = RESET_LINE;
		end
	end

	// state registers, frozen while the clock enable is low
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			have_first_q <= 1'b0;
			mismatch_q <= 1'b0;
			have_prev_q <= 1'b0;
			first_len_q <= RESET_LINE;
			prev_len_q <= RESET_LINE;
			cnt_q <= RESET_LINE;
			prev_cnt_q <= RESET_LINE;
			unsteady_evt_q <= 1'b0;
			len_changed_evt_q <= 1'b0;
			cnt_changed_evt_q <= 1'b0;
		end
		else if (clk_en)
		begin
			have_first_q <= have_first_d;
			mismatch_q <= mismatch_d;
			have_prev_q <= have_prev_d;
			first_len_q <= first_len_d;
			prev_len_q <= prev_len_d;
			cnt_q <= cnt_d;
			prev_cnt_q <= prev_cnt_d;
			unsteady_evt_q <= unsteady_d;
			len_changed_evt_q <= len_chg_d;
			cnt_changed_evt_q <= cnt_chg_d;
		end
	end

endmodule

// [rpsr_top.sv]
// per-port receive status registers with port-selected host access
// Summary of operation
// - Host reads of the per-port registers reach the port named by port select; host writes to them are ignored.
// - Bit 7 sets when a frame's lines differ in length and stays set until the register is read.
// - Bit 6 sets on a detected line length change and clears when the register is read.
// - Bit 5 sets on a link encoding error, seen only with error counting on and threshold above one.
// - Bit 4 sets when the packet buffer overflows and clears when the register is read.
// - Read-only bit 3 summarises a CSI-2 receive error whose details live elsewhere.
// - Read-only bit 2 shows a settled frequency measurement and bit 1 an absent link clock.
// - Bit 0 sets when the line count per frame changes and clears when the register is read.
// - The integer MHz part of the measured link frequency reads as a byte at its own address.
// - The 1/256 MHz fraction of the measured frequency reads as a byte at the next address.
// - Sensor fields sent by the remote serializer are loaded into the registers with no host action.
// - The first sensor register holds six alarm flags in bits 5:0 with bits 7:6 reading zero.
// - The second sensor register holds voltage levels in bits 6:4 and 2:0, bits 7 and 3 zero.
// - The third sensor register holds the temperature level in bits 2:0, bits 7:3 zero.
`timescale 1ns/1ps
module rpsr_top (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [rpsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rpsr_pkg::DATA_W-1:0] reg_wdata,
	output logic [rpsr_pkg::DATA_W-1:0] rd_data_q,
	output logic rd_valid_q,
	output logic [rpsr_pkg::PORT_W-1:0] selected_port_q,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] line_end,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::LINE_W-1:0] line_length,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] frame_end,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] encode_error_evt,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] link_error_count_en,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::THRESH_W-1:0] link_error_threshold,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] buffer_overflow_evt,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] csi_rx_error,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] freq_measure_settled,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] link_clock_absent,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] freq_update,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::FREQ_W-1:0] freq_value,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] sensor_load,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::ALARM_W-1:0] sensor_alarm,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::LEVEL_W-1:0] sensor_volt1,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::LEVEL_W-1:0] sensor_volt0,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::LEVEL_W-1:0] sensor_temp
);
	import rpsr_pkg::*;

	// host view of the group; every byte except port select follows the selected port
	//   port select    read port in bits 1:0, the other bits read zero
	//   status two     sticky event flags in bits 7, 6, 5, 4 and 0, live levels in 3, 2, 1
	//   freq integer   whole MHz of the latest measurement
	//   freq fraction  1/256 MHz; a pending snapshot from an integer read is returned first
	//   remote alarm   six serializer alarm flags in bits 5:0
	//   remote voltage two sampled levels in bits 6:4 and 2:0
	//   remote temp    one sampled level in bits 2:0
	// every byte except port select ignores host writes, so a stray write cannot fake a flag
	// sticky flags clear only on a taken read of status two with their own port selected;
	// a host polling another port leaves them pending, which is intended
	// the live bits are not latched, so two reads may differ while a level is changing
	// an event arriving in the clearing cycle survives; losing it would hide an overflow
	// while clk_en is low nothing is taken: strobes and events of that cycle are dropped,
	// so an event source must hold its pulse until an enabled edge if it must not be lost
	// unmapped offsets answer with zero rather than leaving the host without an answer
	// the frequency snapshot disarms on the fraction read, so a lone fraction read is live
	// line tracking is per port and runs whether or not that port is selected
	// the answer is registered: rd_valid_q pulses one enabled edge after the strobe
	// rd_data_q keeps the last answer until the next taken read, for a slow host side

	// true when the access is a read of the given address
	function automatic logic read_of(
		input logic rd,
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] target
	);
		read_of = rd && (addr == target);
	endfunction

	// true when port p is the one the host currently addresses
	function automatic logic port_hit(
		input logic [PORT_W-1:0] sel,
		input int p
	);
		port_hit = (sel == PORT_W'(p));
	endfunction

	// video timing change events from each port's tracker
	logic [NUM_PORTS-1:0] unsteady_evt;
	logic [NUM_PORTS-1:0] len_changed_evt;
	logic [NUM_PORTS-1:0] cnt_changed_evt;

	// port select state
	logic [PORT_W-1:0] sel_d;

	// sticky flags of status register two, one bit per port
	logic [NUM_PORTS-1:0] unsteady_q, unsteady_d;
	logic [NUM_PORTS-1:0] len_chg_q, len_chg_d;
	logic [NUM_PORTS-1:0] enc_err_q, enc_err_d;
	logic [NUM_PORTS-1:0] buf_err_q, buf_err_d;
	logic [NUM_PORTS-1:0] cnt_chg_q, cnt_chg_d;
	logic [NUM_PORTS-1:0] sts_clear;
	logic [NUM_PORTS-1:0] enc_seen;

	// frequency measurement and the fraction snapshot
	logic [NUM_PORTS-1:0][FREQ_W-1:0] freq_q, freq_d;
	logic [NUM_PORTS-1:0][DATA_W-1:0] frac_snap_q, frac_snap_d;
	logic [NUM_PORTS-1:0] snap_armed_q, snap_armed_d;

	// remote sensor fields
	logic [NUM_PORTS-1:0][ALARM_W-1:0] alarm_q, alarm_d;
	logic [NUM_PORTS-1:0][LEVEL_W-1:0] volt1_q, volt1_d;
	logic [NUM_PORTS-1:0][LEVEL_W-1:0] volt0_q, volt0_d;
	logic [NUM_PORTS-1:0][LEVEL_W-1:0] temp_q, temp_d;

	// read path
	logic [DATA_W-1:0] rd_data_d;
	logic rd_valid_d;

	// one line tracker per receive port
	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++)
		begin : g_track
			rpsr_line_tracker u_track (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.clk_en(clk_en),
				.line_end(line_end[g]),
				.line_length(line_length[g]),
				.frame_end(frame_end[g]),
				.unsteady_evt_q(unsteady_evt[g]),
				.len_changed_evt_q(len_changed_evt[g]),
				.cnt_changed_evt_q(cnt_changed_evt[g])
			);
		end
	endgenerate

	// port select: only the read port field is kept, other bits read zero
	always_comb
	begin
		sel_d = selected_port_q;
		if (reg_wr && reg_addr == ADDR_PORT_SELECT)
		begin
			sel_d = reg_wdata[PSEL_PORT_LSB +: PORT_W];
		end
	end

	// port select register
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			selected_port_q <= RESET_PORT;
		end
		else if (clk_en)
		begin
			selected_port_q <= sel_d;
		end
	end

	// sticky flags: set has priority, a read of the selected port clears
	always_comb
	begin
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			sts_clear[p] = read_of(reg_rd, reg_addr, ADDR_LINK_STATUS_TWO)
				&& port_hit(selected_port_q, p);
			// without error counting the receiver drops lock first and the error goes unseen
			enc_seen[p] = encode_error_evt[p] && link_error_count_en[p]
				&& (link_error_threshold[p] > ENC_ERR_MIN_THRESH);
			unsteady_d[p] = unsteady_evt[p] | (unsteady_q[p] & ~sts_clear[p]);
			len_chg_d[p] = len_changed_evt[p] | (len_chg_q[p] & ~sts_clear[p]);
			enc_err_d[p] = enc_seen[p] | (enc_err_q[p] & ~sts_clear[p]);
			buf_err_d[p] = buffer_overflow_evt[p] | (buf_err_q[p] & ~sts_clear[p]);
			cnt_chg_d[p] = cnt_changed_evt[p] | (cnt_chg_q[p] & ~sts_clear[p]);
		end
	end

	// sticky flag registers
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			unsteady_q <= '0;
			len_chg_q <= '0;
			enc_err_q <= '0;
			buf_err_q <= '0;
			cnt_chg_q <= '0;
		end
		else if (clk_en)
		begin
			unsteady_q <= unsteady_d;
			len_chg_q <= len_chg_d;
			enc_err_q <= enc_err_d;
			buf_err_q <= buf_err_d;
			cnt_chg_q <= cnt_chg_d;
		end
	end

	// frequency result; reading the integer byte snapshots the fraction so
	// a two-byte read is coherent even if a new measurement lands between
	always_comb
	begin
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			freq_d[p] = freq_update[p] ? freq_value[p] : freq_q[p];
			frac_snap_d[p] = frac_snap_q[p];
			snap_armed_d[p] = snap_armed_q[p];
			if (read_of(reg_rd, reg_addr, ADDR_FREQ_INTEGER_MHZ) && port_hit(selected_port_q, p))
			begin
				frac_snap_d[p] = freq_q[p][DATA_W-1:0];
				snap_armed_d[p] = 1'b1;
			end
			else if (read_of(reg_rd, reg_addr, ADDR_FREQ_FRACTION)
				&& port_hit(selected_port_q, p))
			begin
				snap_armed_d[p] = 1'b0;
			end
		end
	end

	// frequency registers
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			for (int p = 0; p < NUM_PORTS; p++)
			begin
				freq_q[p] <= RESET_FREQ;
				frac_snap_q[p] <= RESET_BYTE;
			end
			snap_armed_q <= '0;
		end
		else if (clk_en)
		begin
			freq_q <= freq_d;
			frac_snap_q <= frac_snap_d;
			snap_armed_q <= snap_armed_d;
		end
	end

	// remote sensor fields follow the forward channel, the host never writes them
	always_comb
	begin
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			alarm_d[p] = sensor_load[p] ? sensor_alarm[p] : alarm_q[p];
			volt1_d[p] = sensor_load[p] ? sensor_volt1[p] : volt1_q[p];
			volt0_d[p] = sensor_load[p] ? sensor_volt0[p] : volt0_q[p];
			temp_d[p] = sensor_load[p] ? sensor_temp[p] : temp_q[p];
		end
	end

	// remote sensor registers
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			alarm_q <= '0;
			volt1_q <= '0;
			volt0_q <= '0;
			temp_q <= '0;
		end
		else if (clk_en)
		begin
			alarm_q <= alarm_d;
			volt1_q <= volt1_d;
			volt0_q <= volt0_d;
			temp_q <= temp_d;
		end
	end

	// read mux over the selected port; unmapped offsets read zero
	always_comb
	begin
		logic [PORT_W-1:0] s;
		s = selected_port_q;
		rd_valid_d = reg_rd;
		rd_data_d = rd_data_q;
		if (reg_rd)
		begin
			rd_data_d = RESET_BYTE;
			unique case (reg_addr)
				ADDR_PORT_SELECT:
				begin
					rd_data_d[PSEL_PORT_LSB +: PORT_W] = s;
				end
				ADDR_LINK_STATUS_TWO:
				begin
					rd_data_d[STS_LINE_LEN_UNSTEADY] = unsteady_q[s];
					rd_data_d[STS_LINE_LEN_CHANGED] = len_chg_q[s];
					rd_data_d[STS_ENCODING_ERROR] = enc_err_q[s];
					rd_data_d[STS_BUFFER_ERROR] = buf_err_q[s];
					rd_data_d[STS_CSI_ERROR] = csi_rx_error[s];
					rd_data_d[STS_FREQ_SETTLED] = freq_measure_settled[s];
					rd_data_d[STS_CLOCK_ABSENT] = link_clock_absent[s];
					rd_data_d[STS_LINE_CNT_CHANGED] = cnt_chg_q[s];
				end
				ADDR_FREQ_INTEGER_MHZ:
				begin
					rd_data_d = freq_q[s][FREQ_W-1:DATA_W];
				end
				ADDR_FREQ_FRACTION:
				begin
					// without a prior integer read the live fraction is returned
					rd_data_d = snap_armed_q[s] ? frac_snap_q[s]
						: freq_q[s][DATA_W-1:0];
				end
				ADDR_REMOTE_ALARM:
				begin
					rd_data_d[ALARM_W-1:0] = alarm_q[s];
				end
				ADDR_REMOTE_VOLTAGE:
				begin
					rd_data_d[VOLT1_LSB +: LEVEL_W] = volt1_q[s];
					rd_data_d[VOLT0_LSB +: LEVEL_W] = volt0_q[s];
				end
				ADDR_REMOTE_TEMP:
				begin
					rd_data_d[TEMP_LSB +: LEVEL_W] = temp_q[s];
				end
				default:
				begin
					rd_data_d = RESET_BYTE;
				end
			endcase
		end
	end

	// read data holds until the next read
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			rd_data_q <= RESET_BYTE;
			rd_valid_q <= 1'b0;
		end
		else if (clk_en)
		begin
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

endmodule

// [rpsr_sva.sv]
// checker for the receive port status register group
`timescale 1ns/1ps
module rpsr_sva (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [rpsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rpsr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [rpsr_pkg::DATA_W-1:0] rd_data_q,
	input wire logic rd_valid_q,
	input wire logic [rpsr_pkg::PORT_W-1:0] selected_port_q,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] buffer_overflow_evt,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] csi_rx_error,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] freq_measure_settled,
	input wire logic [rpsr_pkg::NUM_PORTS-1:0] link_clock_absent
);
	import rpsr_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// taken accesses; clk_en gates each one since a frozen edge takes nothing
	wire rd_go = reg_rd && clk_en;
	wire rd_sts = rd_go && reg_addr == ADDR_LINK_STATUS_TWO;
	wire sel_wr = reg_wr && clk_en && reg_addr == ADDR_PORT_SELECT;
	wire buf_sel = buffer_overflow_evt[selected_port_q] && clk_en;

	a_read_answer: assert property (clk_en |=> rd_valid_q == $past(reg_rd))
		else $error("read valid not one edge after the read strobe");
	a_port_write: assert property (sel_wr |=>
		selected_port_q == $past(reg_wdata[PSEL_PORT_LSB +: PORT_W]))
		else $error("port select write not taken");
	a_port_hold: assert property (!sel_wr |=> $stable(selected_port_q))
		else $error("port select moved without a write");
	a_alarm_rsv: assert property (rd_go && reg_addr == ADDR_REMOTE_ALARM |=>
		rd_data_q[7:6] == 2'h0)
		else $error("alarm register reserved bits not zero");
	a_volt_rsv: assert property (rd_go && reg_addr == ADDR_REMOTE_VOLTAGE |=>
		!rd_data_q[7] && !rd_data_q[3])
		else $error("voltage register reserved bits not zero");
	a_temp_rsv: assert property (rd_go && reg_addr == ADDR_REMOTE_TEMP |=>
		rd_data_q[7:3] == 5'h00)
		else $error("temperature register reserved bits not zero");
	a_live_bits: assert property (rd_sts |=> rd_data_q[3:1] == $past({
		csi_rx_error[selected_port_q], freq_measure_settled[selected_port_q],
		link_clock_absent[selected_port_q]}))
		else $error("live status bits differ from the selected port");
	a_buf_visible: assert property (buf_sel ##1 rd_sts && $stable(selected_port_q) |=>
		rd_data_q[STS_BUFFER_ERROR])
		else $error("overflow flag not seen by the next read");
	a_buf_clear: assert property (rd_sts && !buf_sel ##1 rd_sts && $stable(selected_port_q)
		|=> !rd_data_q[STS_BUFFER_ERROR])
		else $error("overflow flag not cleared by its read");
	a_set_wins: assert property (rd_sts && buf_sel ##1 rd_sts && $stable(selected_port_q)
		|=> rd_data_q[STS_BUFFER_ERROR])
		else $error("overflow lost when it met a clearing read");

	c_flag_read: cover property (rd_sts ##1 rd_valid_q && rd_data_q[STS_BUFFER_ERROR]);
	c_port_move: cover property (sel_wr ##1 $changed(selected_port_q));
	c_frac_read: cover property (rd_go && reg_addr == ADDR_FREQ_FRACTION);
endmodule

bind rpsr_top rpsr_sva i_sva (.ref_clk, .reset_n, .clk_en, .reg_rd, .reg_wr, .reg_addr,
	.reg_wdata, .rd_data_q, .rd_valid_q, .selected_port_q, .buffer_overflow_evt,
	.csi_rx_error, .freq_measure_settled, .link_clock_absent);

// [rpsr_remote_ser.sv]
// remote serializer model pushing sensor fields over the forward channel
`timescale 1ns/1ps
module rpsr_remote_ser (
	input wire logic ref_clk,
	output logic [rpsr_pkg::NUM_PORTS-1:0] sensor_load,
	output logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::ALARM_W-1:0] sensor_alarm,
	output logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::LEVEL_W-1:0] sensor_volt1,
	output logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::LEVEL_W-1:0] sensor_volt0,
	output logic [rpsr_pkg::NUM_PORTS-1:0][rpsr_pkg::LEVEL_W-1:0] sensor_temp
);
	import rpsr_pkg::*;
	// quiet link until the first frame
	initial
	begin
		sensor_load = '0;
		{sensor_alarm, sensor_volt1, sensor_volt0, sensor_temp} = '0;
	end
	// one frame after gap+1 cycles; fields are scrambled after the pulse so stale data is useless
	task automatic send(input int p, input logic [14:0] f, input int gap);
		repeat (gap + 1) @(negedge ref_clk);
		{sensor_alarm[p], sensor_volt1[p], sensor_volt0[p], sensor_temp[p]} = f;
		sensor_load[p] = 1'h1;
		@(negedge ref_clk);
		sensor_load[p] = 1'h0;
		{sensor_alarm[p], sensor_volt1[p], sensor_volt0[p], sensor_temp[p]} = ~f;
	endtask
endmodule

// [testbench.sv]
// self-checking bench for the receive port status register group
`timescale 1ns/1ps
module testbench;
	import rpsr_pkg::*;
	logic ref_clk = 1'h0;
	logic reset_n = 1'h0;
	logic clk_en = 1'h1;
	logic reg_rd = 1'h0;
	logic reg_wr = 1'h0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic [DATA_W-1:0] rd_data_q;
	logic rd_valid_q;
	logic [PORT_W-1:0] selected_port_q;
	logic [NUM_PORTS-1:0] line_end = '0, frame_end = '0, encode_error_evt = '0;
	logic [NUM_PORTS-1:0] link_error_count_en = '0, buffer_overflow_evt = '0, csi_rx_error = '0;
	logic [NUM_PORTS-1:0] freq_measure_settled = '0, link_clock_absent = '0, freq_update = '0;
	logic [NUM_PORTS-1:0] sensor_load;
	logic [NUM_PORTS-1:0][LINE_W-1:0] line_length = '0;
	logic [NUM_PORTS-1:0][THRESH_W-1:0] link_error_threshold = '0;
	logic [NUM_PORTS-1:0][FREQ_W-1:0] freq_value = '0;
	logic [NUM_PORTS-1:0][ALARM_W-1:0] sensor_alarm;
	logic [NUM_PORTS-1:0][LEVEL_W-1:0] sensor_volt1, sensor_volt0, sensor_temp;
	logic [DATA_W-1:0] exp_q[$];
	logic [14:0] snd[NUM_PORTS];
	logic [7:0] frac_old;
	logic [31:0] seed = 32'hC9B1;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;

	rpsr_top i_dut (.ref_clk, .reset_n, .clk_en, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
		.rd_data_q, .rd_valid_q, .selected_port_q, .line_end, .line_length, .frame_end,
		.encode_error_evt, .link_error_count_en, .link_error_threshold, .buffer_overflow_evt,
		.csi_rx_error, .freq_measure_settled, .link_clock_absent, .freq_update, .freq_value,
		.sensor_load, .sensor_alarm, .sensor_volt1, .sensor_volt0, .sensor_temp);
	rpsr_remote_ser i_ser (.ref_clk, .sensor_load, .sensor_alarm, .sensor_volt1,
		.sensor_volt0, .sensor_temp);

	// 25 MHz reference clock
	always #20 ref_clk = ~ref_clk;

	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] live(input int p);
		return {4'h0, csi_rx_error[p], freq_measure_settled[p], link_clock_absent[p], 1'h0};
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH time %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge ref_clk);
		reg_wr = 1'h0;
	endtask
	// keep leaves the strobe up so the next read follows back to back
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic keep = 1'h0,
		input logic [3:0] ovf = 4'h0);
		@(negedge ref_clk);
		reg_rd = 1'h1;
		reg_addr = a;
		buffer_overflow_evt = ovf;
		encode_error_evt = '0;
		exp_q.push_back(e);
		if (!keep)
		begin
			@(negedge ref_clk);
			reg_rd = 1'h0;
			buffer_overflow_evt = '0;
		end
	endtask
	task automatic ln(input int len, input logic fe);
		@(negedge ref_clk);
		line_end[2] = 1'h1;
		line_length[2] = len[15:0];
		frame_end[2] = fe;
		@(negedge ref_clk);
		line_end[2] = 1'h0;
		frame_end[2] = 1'h0;
	endtask

	// answered reads meet the oldest note; an answer with no note is a mismatch
	always @(negedge ref_clk)
	begin
		if (rd_valid_q === 1'h1)
			chk(rd_data_q, exp_q.size() ? exp_q.pop_front() : 8'hXX);
	end

	// hang guard, far above the fewer than two hundred cycles the run needs
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			errors++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (10) @(negedge ref_clk);
		reset_n = 1'h1;
		// defaults, with unmapped neighbours reading zero
		for (int a = 32'h4D; a <= 32'h54; a++)
			rd(a[7:0], 8'h00);
		// random live levels, frequencies and sensor frames, prompt and slow
		seed = nx(seed);
		{csi_rx_error, freq_measure_settled, link_clock_absent} = seed[11:0];
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			seed = nx(seed);
			freq_value[p] = seed[15:0];
			snd[p] = seed[30:16];
			i_ser.send(p, snd[p], p);
		end
		@(negedge ref_clk);
		freq_update = '1;
		@(negedge ref_clk);
		freq_update = '0;
		// each port in turn; a write to a read-only byte must leave it alone
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			seed = nx(seed);
			wr(ADDR_PORT_SELECT, {seed[7:2], p[1:0]});
			rd(ADDR_PORT_SELECT, {6'h00, p[1:0]});
			wr(ADDR_FREQ_INTEGER_MHZ, 8'hFF);
			rd(ADDR_FREQ_INTEGER_MHZ, freq_value[p][15:8]);
			rd(ADDR_FREQ_FRACTION, freq_value[p][7:0]);
			rd(ADDR_REMOTE_ALARM, {2'h0, snd[p][14:9]});
			rd(ADDR_REMOTE_VOLTAGE, {1'h0, snd[p][8:6], 1'h0, snd[p][5:3]});
			rd(ADDR_REMOTE_TEMP, {5'h00, snd[p][2:0]});
			rd(ADDR_LINK_STATUS_TWO, live(p));
		end
		// overflow on ports 1 and 2; a clearing read meets a fresh overflow
		wr(ADDR_PORT_SELECT, 8'h02);
		@(negedge ref_clk);
		buffer_overflow_evt = 4'h6;
		rd(ADDR_LINK_STATUS_TWO, live(2) | 8'h10);
		rd(ADDR_LINK_STATUS_TWO, live(2), 1'h1, 4'h4);
		rd(ADDR_LINK_STATUS_TWO, live(2) | 8'h10, 1'h1);
		rd(ADDR_LINK_STATUS_TWO, live(2));
		wr(ADDR_PORT_SELECT, 8'h01);
		rd(ADDR_LINK_STATUS_TWO, live(1) | 8'h10);
		// encoding errors count only with counting on and a threshold above one
		wr(ADDR_PORT_SELECT, 8'h02);
		for (int k = 0; k < 4; k++)
		begin
			link_error_count_en[2] = (k != 2);
			link_error_threshold[2] = (k == 1) ? 3'h1 : 3'h2 + k[2:0];
			@(negedge ref_clk);
			encode_error_evt[2] = 1'h1;
			rd(ADDR_LINK_STATUS_TWO, live(2) | ((link_error_count_en[2] &&
				link_error_threshold[2] > 3'h1) ? 8'h20 : 8'h00));
		end
		// a frozen clock takes neither the read nor the overflow
		@(negedge ref_clk);
		clk_en = 1'h0;
		reg_rd = 1'h1;
		reg_addr = ADDR_LINK_STATUS_TWO;
		buffer_overflow_evt = 4'h4;
		@(negedge ref_clk);
		clk_en = 1'h1;
		reg_rd = 1'h0;
		buffer_overflow_evt = 4'h0;
		rd(ADDR_LINK_STATUS_TWO, live(2));
		// a new measurement between the two bytes must not tear the pair
		frac_old = freq_value[2][7:0];
		rd(ADDR_FREQ_INTEGER_MHZ, freq_value[2][15:8]);
		seed = nx(seed);
		freq_value[2] = seed[15:0];
		freq_update[2] = 1'h1;
		@(negedge ref_clk);
		freq_update[2] = 1'h0;
		rd(ADDR_FREQ_FRACTION, frac_old);
		rd(ADDR_FREQ_FRACTION, freq_value[2][7:0]);
		// frames: steady, longer lines, then uneven lines with one line more
		ln(100, 1'h0);
		ln(100, 1'h1);
		rd(ADDR_LINK_STATUS_TWO, live(2));
		ln(120, 1'h0);
		ln(120, 1'h1);
		rd(ADDR_LINK_STATUS_TWO, live(2) | 8'h40);
		ln(120, 1'h0);
		ln(130, 1'h0);
		ln(130, 1'h1);
		rd(ADDR_LINK_STATUS_TWO, live(2) | 8'h81);
		repeat (3) @(negedge ref_clk);
		if (exp_q.size() != 0)
			errors++;
		wrap_up();
	end
endmodule
